// *** bench/adcseq_fe_model.sv ***
// Purpose: front-end stand-in returning a channel-tagged result code
// Assumes: the sequencer samples the result while busy
// Notes: drives the inverse of the held code while idle, so stale samples show

`timescale 1ns/1ns

module adcseq_fe_model
  import adcseq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // converter control
  input wire logic conv_start_in,
  input wire logic conv_busy_in,
  input wire adcseq_cfg_s conv_cfg_in,
  // result
  output logic [RESULT_W-1:0] conv_data_out
);
  logic [RESULT_W-1:0] held;

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      held <= 14'h0000;
    end
    else if (conv_start_in)
    begin
      // channels 8 and up set the sign bit
      held <= {conv_cfg_in.channel, 10'h2A5};
    end
  end

  assign conv_data_out = conv_busy_in ? held : ~held;

endmodule : adcseq_fe_model

// *** bench/adcseq_top_asserts.sv ***
// Purpose: temporal checks on the converter sequencer ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes: expected length follows the decimation seen at each start

`timescale 1ns/1ns

module adcseq_top_asserts
  import adcseq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_rdata_out,
  // conversion and triggers
  input wire adcseq_cfg_s conv_cfg_out,
  input wire logic conv_start_out,
  input wire logic conv_busy_out,
  input wire logic irq_out,
  input wire logic [PIN_COUNT-1:0] per_channel_dma_trigger_out,
  input wire logic any_channel_dma_trigger_out
);
  // ****************************************
  // helper logic
  // ****************************************
  logic [12:0] cyc;
  logic [1:0] dec_q;
  logic [CHAN_W-1:0] ch_q;
  logic [12:0] exp_len;
  logic [7:0] exp_per;

  // cyc loads 1 on the edge where the timer takes the start, and the flag is registered once more
  assign exp_len = 13'(((DECIM_BASE << dec_q) + CONV_OVERHEAD) * SAMPLE_CYCLES + 2);
  assign exp_per = (ch_q < CHAN_FIRST_DIFF) ? 8'(1 << ch_q) : 8'h00;

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cyc <= 13'h0000;
      dec_q <= 2'h0;
      ch_q <= 4'h0;
    end
    else if (conv_start_out)
    begin
      cyc <= 13'h0001;
      dec_q <= conv_cfg_out.decimation_select;
      ch_q <= conv_cfg_out.channel;
    end
    else
    begin
      cyc <= cyc + 13'h0001;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  a_conv_length: assert property ((irq_out || any_channel_dma_trigger_out) |-> cyc == exp_len)
    else $error("completion off the expected cycle");
  a_single_quiet: assert property (irq_out |-> !any_channel_dma_trigger_out && per_channel_dma_trigger_out == 8'h00)
    else $error("single completion raised a dma trigger");
  a_chan_trigger: assert property (any_channel_dma_trigger_out |-> per_channel_dma_trigger_out == exp_per)
    else $error("per-channel trigger does not match channel");
  a_per_any: assert property (|per_channel_dma_trigger_out |-> any_channel_dma_trigger_out)
    else $error("per-channel trigger without any-channel trigger");
  a_busy_end: assert property ($fell(conv_busy_out) |-> irq_out || any_channel_dma_trigger_out)
    else $error("busy ended without a completion");
  a_cfg_hold: assert property (conv_busy_out && !conv_start_out |-> $stable(conv_cfg_out))
    else $error("config moved during a conversion");
  a_seq_restart: assert property (any_channel_dma_trigger_out && conv_busy_out |-> conv_start_out)
    else $error("sequence went on without a start pulse");
  a_low_pad: assert property (sfr_rd_in && sfr_addr_in == ADDR_RESULT_LOW |=> sfr_rdata_out[1:0] == LOW_PAD)
    else $error("low result byte pad bits not zero");

endmodule : adcseq_top_asserts

bind adcseq_top adcseq_top_asserts u_asserts
(
  .clk_sys_in(clk_sys_in),
  .nrst_in(nrst_in),
  .sfr_addr_in(sfr_addr_in),
  .sfr_rd_in(sfr_rd_in),
  .sfr_rdata_out(sfr_rdata_out),
  .conv_cfg_out(conv_cfg_out),
  .conv_start_out(conv_start_out),
  .conv_busy_out(conv_busy_out),
  .irq_out(irq_out),
  .per_channel_dma_trigger_out(per_channel_dma_trigger_out),
  .any_channel_dma_trigger_out(any_channel_dma_trigger_out)
);

// *** bench/tb_top.sv ***
// Purpose: directed register-level tests of the converter sequencer
// Assumes: 20 MHz clock, inputs driven on the falling edge
// Notes: shortest decimation used except in the rate sweep

`timescale 1ns/1ns

module tb_top
  import adcseq_pkg::*;
;
  logic clk_sys_in = 1'h0;
  logic nrst_in = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic ext_pin = 1'h0;
  logic tmr = 1'h0;
  logic [7:0] pins = 8'h0B;
  logic [RESULT_W-1:0] fe_data;
  adcseq_cfg_s cfg;
  logic start;
  logic busy;
  logic irq;
  logic any;
  logic [7:0] per;
  logic [7:0] rdata;
  int bad_count = 0;
  int num_checks = 0;
  int any_cnt = 0;
  int irq_cnt = 0;
  int per_cnt [8];

  adcseq_top DUT
  (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .sfr_addr_in(addr),
    .sfr_wr_in(wr),
    .sfr_rd_in(rd),
    .sfr_wdata_in(wdata),
    .sfr_rdata_out(rdata),
    .external_trigger_pin_in(ext_pin),
    .timer_compare_in(tmr),
    .analog_pin_config_in(pins),
    .conv_data_in(fe_data),
    .conv_cfg_out(cfg),
    .conv_start_out(start),
    .conv_busy_out(busy),
    .irq_out(irq),
    .per_channel_dma_trigger_out(per),
    .any_channel_dma_trigger_out(any)
  );

  adcseq_fe_model u_fe
  (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .conv_start_in(start),
    .conv_busy_in(busy),
    .conv_cfg_in(cfg),
    .conv_data_out(fe_data)
  );

  initial
  begin
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // trigger pulses are one cycle wide, so mid-cycle sampling sees each once
  always @(negedge clk_sys_in)
  begin
    any_cnt += (any === 1'h1);
    irq_cnt += (irq === 1'h1);
    for (int i = 0; i < 8; i++)
      per_cnt[i] += (per[i] === 1'h1);
  end

  // ****************************************
  // tasks
  // ****************************************
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    addr = a;
    wdata = d;
    wr = 1'h1;
    @(negedge clk_sys_in);
    wr = 1'h0;
  endtask : wr_reg

  task rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys_in);
    addr = a;
    rd = 1'h1;
    @(negedge clk_sys_in);
    rd = 1'h0;
    @(negedge clk_sys_in);
    chk(rdata, exp);
  endtask : rd_reg

  task automatic wait_for(ref int cnt, input int n, input int lim);
    int k;
    k = 0;
    while (cnt < n && k < lim)
    begin
      @(negedge clk_sys_in);
      k++;
    end
    chk(8'(cnt >= n), 8'h01);
  endtask : wait_for

  task idle();
    int k;
    k = 0;
    while (busy !== 1'h0 && k < 3000)
    begin
      @(negedge clk_sys_in);
      k++;
    end
    chk({7'h00, busy}, 8'h00);
  endtask : idle

  task clr();
    any_cnt = 0;
    irq_cnt = 0;
    foreach (per_cnt[i])
      per_cnt[i] = 0;
  endtask : clr

  function automatic logic [7:0] hi(input logic [3:0] ch);
    logic [13:0] v;
    v = {ch, 10'h2A5};
    return v[13:6];
  endfunction : hi

  function automatic logic [7:0] lo(input logic [3:0] ch);
    logic [13:0] v;
    v = {ch, 10'h2A5};
    return {v[5:0], 2'h0};
  endfunction : lo

  task give_verdict();
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    clr();
    repeat (5) @(negedge clk_sys_in);
    nrst_in = 1'h1;
    rd_reg(ADDR_CONTROL_STATUS, 8'h33);
    rd_reg(ADDR_SEQUENCE_CONTROL, 8'h10);
    rd_reg(ADDR_RESULT_LOW, 8'h00);
    rd_reg(ADDR_RESULT_HIGH, 8'h00);
    rd_reg(8'hC0, 8'h00);
    wr_reg(ADDR_SINGLE_CONVERSION, 8'h03);
    wait_for(irq_cnt, 1, 600);
    rd_reg(ADDR_CONTROL_STATUS, 8'hB3);
    rd_reg(ADDR_RESULT_LOW, lo(4'h3));
    rd_reg(ADDR_RESULT_HIGH, hi(4'h3));
    rd_reg(ADDR_CONTROL_STATUS, 8'h33);
    chk(8'(any_cnt), 8'h00);
    // sequence 0..3 with pin 2 off, single queued behind it
    clr();
    wr_reg(ADDR_SEQUENCE_CONTROL, 8'h03);
    wr_reg(ADDR_CONTROL_STATUS, 8'h73);
    rd_reg(ADDR_CONTROL_STATUS, 8'h73);
    rd_reg(ADDR_SEQUENCE_CONTROL, 8'h00);
    wait_for(any_cnt, 1, 600);
    rd_reg(ADDR_RESULT_HIGH, hi(4'h0));
    rd_reg(ADDR_SEQUENCE_CONTROL, 8'h01);
    wr_reg(ADDR_SINGLE_CONVERSION, 8'h0C);
    wait_for(irq_cnt, 1, 2000);
    chk({per_cnt[3][1:0], per_cnt[2][1:0], per_cnt[1][1:0], per_cnt[0][1:0]}, 8'h45);
    chk(8'(any_cnt), 8'h03);
    rd_reg(ADDR_SEQUENCE_CONTROL, 8'h04);
    rd_reg(ADDR_CONTROL_STATUS, 8'hB3);
    rd_reg(ADDR_RESULT_HIGH, hi(4'hC));
    // start bit refused when the same write selects another start source
    wr_reg(ADDR_CONTROL_STATUS, 8'h43);
    rd_reg(ADDR_CONTROL_STATUS, 8'h03);
    chk({7'h00, busy}, 8'h00);
    pins = 8'hFF;
    wr_reg(ADDR_SEQUENCE_CONTROL, 8'h09);
    clr();
    ext_pin = 1'h1;
    repeat (4) @(negedge clk_sys_in);
    ext_pin = 1'h0;
    wait_for(any_cnt, 2, 1200);
    idle();
    rd_reg(ADDR_RESULT_HIGH, hi(4'h9));
    rd_reg(ADDR_SEQUENCE_CONTROL, 8'h0A);
    wr_reg(ADDR_CONTROL_STATUS, 8'h23);
    wr_reg(ADDR_SEQUENCE_CONTROL, 8'h0C);
    clr();
    tmr = 1'h1;
    @(negedge clk_sys_in);
    tmr = 1'h0;
    wait_for(any_cnt, 1, 600);
    idle();
    rd_reg(ADDR_SEQUENCE_CONTROL, 8'h0C);
    chk(8'(any_cnt), 8'h01);
    // free-running: a sequence already under way keeps restarting
    wr_reg(ADDR_SEQUENCE_CONTROL, 8'h00);
    clr();
    wr_reg(ADDR_CONTROL_STATUS, 8'h73);
    rd_reg(ADDR_CONTROL_STATUS, 8'hF3);
    wr_reg(ADDR_CONTROL_STATUS, 8'h13);
    wait_for(any_cnt, 3, 1500);
    wr_reg(ADDR_CONTROL_STATUS, 8'h33);
    idle();
    chk(8'(per_cnt[0]), 8'(any_cnt));
    for (int d = 0; d < 4; d++)
    begin
      clr();
      wr_reg(ADDR_SINGLE_CONVERSION, {2'(d), 2'(d), 4'hC});
      chk(cfg, {2'(d), 2'(d), 4'hC});
      rd_reg(ADDR_SINGLE_CONVERSION, {2'(d), 2'(d), 4'hC});
      wait_for(irq_cnt, 1, 3000);
    end
    give_verdict();
  end

  initial
  begin
    #(40000 * 50);
    bad_count++;
    give_verdict();
  end

endmodule : tb_top

// *** design/adcseq_conv_timer.sv ***
// Purpose: times one conversion from its start pulse to its done pulse
// Assumes: start only while idle; decimation held for the whole conversion
// Notes: done comes (rate + overhead) sample periods after start is taken

`timescale 1ns/1ns

module adcseq_conv_timer
  import adcseq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // control
  input wire logic start_in,
  input wire logic [1:0] decimation_select_in,
  // status
  output logic busy_out,
  output logic done_out
);

  logic [PRE_CNT_W-1:0] pre_cnt;
  logic [SMP_CNT_W-1:0] smp_cnt;
  logic [SMP_CNT_W-1:0] smp_last;
  logic last_cycle;

  function automatic logic [SMP_CNT_W-1:0] periods_of(input logic [1:0] sel);
    periods_of = SMP_CNT_W'((DECIM_BASE << sel) + CONV_OVERHEAD);
  endfunction : periods_of

  assign smp_last = periods_of(decimation_select_in) - SMP_CNT_W'(1);
  assign last_cycle = busy_out && (pre_cnt == PRE_CNT_W'(SAMPLE_CYCLES - 1)) && (smp_cnt == smp_last);

  // ****************************************
  // sample prescaler and period counter
  // ****************************************
  // fixed division of the system clock into sample periods
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pre_cnt <= '0;
      smp_cnt <= '0;
    end
    else if (start_in || !busy_out)
    begin
      pre_cnt <= '0;
      smp_cnt <= '0;
    end
    else if (pre_cnt == PRE_CNT_W'(SAMPLE_CYCLES - 1))
    begin
      pre_cnt <= '0;
      smp_cnt <= smp_cnt + SMP_CNT_W'(1);
    end
    else
    begin
      pre_cnt <= pre_cnt + PRE_CNT_W'(1);
    end
  end

  // ****************************************
  // busy and done
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= last_cycle;
      if (start_in)
      begin
        busy_out <= 1'b1;
      end
      else if (last_cycle)
      begin
        busy_out <= 1'b0;
      end
    end
  end

endmodule : adcseq_conv_timer

// *** design/adcseq_pkg.sv ***
// Purpose: shared constants and types of the converter sequencer
// Assumes: 8-bit special-function register bus, one 20 MHz clock
// Notes: register layouts of sequence and single registers are identical

package adcseq_pkg;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [7:0] ADDR_CONTROL_STATUS = 8'hB4;
  localparam logic [7:0] ADDR_SEQUENCE_CONTROL = 8'hB5;
  localparam logic [7:0] ADDR_SINGLE_CONVERSION = 8'hB6;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hBA;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hBB;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int CTRL_DONE_BIT = 7;
  localparam int CTRL_START_BIT = 6;
  localparam int CTRL_START_EVENT_SELECT_LSB = 4;
  localparam int CTRL_LOW_MSB = 3;
  localparam logic [3:0] CTRL_LOW_RST = 4'h3;
  localparam logic [1:0] LOW_PAD = 2'h0;
  localparam logic [7:0] SEQ_CFG_RST = 8'h10;
  localparam logic [7:0] SINGLE_CFG_RST = 8'h00;
  localparam int RESULT_W = 14;
  localparam int RESULT_LOW_W = 6;
  localparam logic [RESULT_W-1:0] RESULT_RST = 14'h0000;

  // ****************************************
  // channel numbering
  // ****************************************
  localparam int CHAN_W = 4;
  localparam int PIN_COUNT = 8;
  localparam logic [CHAN_W-1:0] CHAN_FIRST_SINGLE = 4'h0;
  localparam logic [CHAN_W-1:0] CHAN_FIRST_DIFF = 4'h8;
  localparam logic [CHAN_W-1:0] CHAN_FIRST_LONE = 4'hC;

  // ****************************************
  // timing
  // ****************************************
  localparam real CLK_FREQ_MHZ = 20.0;
  localparam real SAMPLE_PERIOD_US = 0.25;
  localparam int SAMPLE_CYCLES_RAW = int'($ceil(SAMPLE_PERIOD_US * CLK_FREQ_MHZ));
  localparam int SAMPLE_CYCLES = (SAMPLE_CYCLES_RAW < 1) ? 1 : SAMPLE_CYCLES_RAW;
  localparam int DECIM_BASE = 64;
  localparam int CONV_OVERHEAD = 16;
  localparam int SMP_CNT_W = 10;
  localparam int PRE_CNT_W = 3;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0]
  {
    START_EVENT_SELECT_EXT_PIN = 2'b00,
    START_EVENT_SELECT_FREE_RUN = 2'b01,
    START_EVENT_SELECT_TIMER = 2'b10,
    START_EVENT_SELECT_SOFTWARE = 2'b11
  } adcseq_start_sel_e;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_SEQ = 3'b010,
    ST_SINGLE = 3'b100
  } adcseq_state_e;

  typedef struct packed
  {
    logic [1:0] reference_select;
    logic [1:0] decimation_select;
    logic [CHAN_W-1:0] channel;
  } adcseq_cfg_s;

  typedef struct packed
  {
    logic found;
    logic [CHAN_W-1:0] channel;
  } adcseq_pick_s;

endpackage : adcseq_pkg

// *** design/adcseq_top.sv ***
// Purpose: converter control: sequences, single conversions, results, triggers
// Assumes: front end delivers a two's-complement result, same clock domain
// Notes: registers reached over the special-function register port
//
// Behaviour
// - conversion end sets done flag, loads result
// - done flag stays high if unread
// - start bit launches only when selected, idle
// - start selector chooses pin, free-run, timer, software
// - end channel picks single-ended, differential or lone
// - skip channels whose pins are not analog
// - single write starts now or after sequence
// - single register encoded like sequence register
// - results are two's complement
// - result left-aligned, low two bits zero
// - channel readback: current, last plus one, or written
// - results lag the conversion in progress
// - decimation codes map to 64..512
// - conversion takes rate plus 16 sample periods
// - interrupt only for written single conversions
// - DMA trigger for each sequence conversion only
// - eight per-channel DMA triggers for channels 0..7
// - any-channel DMA trigger for each sequence sample

`timescale 1ns/1ns

module adcseq_top
  import adcseq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // special-function register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  // start events
  input wire logic external_trigger_pin_in,
  input wire logic timer_compare_in,
  input wire logic [PIN_COUNT-1:0] analog_pin_config_in,
  // analog front end
  input wire logic [RESULT_W-1:0] conv_data_in,
  output adcseq_cfg_s conv_cfg_out,
  output logic conv_start_out,
  output logic conv_busy_out,
  // interrupt and DMA
  output logic irq_out,
  output logic [PIN_COUNT-1:0] per_channel_dma_trigger_out,
  output logic any_channel_dma_trigger_out
);

  adcseq_state_e state;
  adcseq_start_sel_e start_event_select;
  adcseq_cfg_s sequence_control_reg;
  adcseq_cfg_s single_conversion_reg;
  logic [CTRL_LOW_MSB:0] ctrl_low;
  logic sequence_start_bit;
  logic done_flag;
  logic [RESULT_W-1:0] result;
  logic [CHAN_W-1:0] channel_view;
  logic [CHAN_W-1:0] cur_ch;
  logic single_pending;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic conv_done;

  logic wr_ctrl;
  logic wr_seq;
  logic wr_single;
  logic rd_high;
  logic sw_start;
  logic seq_trigger;
  logic single_req;
  logic seq_last_conv;
  adcseq_pick_s pick_first;
  adcseq_pick_s pick_next;

  // ****************************************
  // channel selection helpers
  // ****************************************
  // differential pair needs both of its pins configured analog
  function automatic logic chan_ok(input logic [CHAN_W-1:0] ch, input logic [PIN_COUNT-1:0] pins);
    logic [2:0] pair;
    pair = 3'(ch - CHAN_FIRST_DIFF) << 1;
    if (ch < CHAN_FIRST_DIFF)
      chan_ok = pins[ch[2:0]];
    else if (ch < CHAN_FIRST_LONE)
      chan_ok = pins[pair] && pins[pair + 3'h1];
    else
      chan_ok = 1'b1;
  endfunction : chan_ok

  // lowest usable channel in lo..hi
  function automatic adcseq_pick_s pick(input logic [CHAN_W:0] lo, input logic [CHAN_W-1:0] hi,
                                        input logic [PIN_COUNT-1:0] pins);
    adcseq_pick_s res;
    res = '0;
    for (int i = 15; i >= 0; i--)
    begin
      if ((i >= int'(lo)) && (i <= int'(hi)) && chan_ok(CHAN_W'(i), pins))
      begin
        res.found = 1'b1;
        res.channel = CHAN_W'(i);
      end
    end
    pick = res;
  endfunction : pick

  // first channel of a sequence from its end channel
  function automatic logic [CHAN_W:0] seq_first_of(input logic [CHAN_W-1:0] last);
    if (last < CHAN_FIRST_DIFF)
      seq_first_of = {1'b0, CHAN_FIRST_SINGLE};
    else if (last < CHAN_FIRST_LONE)
      seq_first_of = {1'b0, CHAN_FIRST_DIFF};
    else
      seq_first_of = {1'b0, last};
  endfunction : seq_first_of

  // ****************************************
  // bus decode and start requests
  // ****************************************
  assign wr_ctrl = sfr_wr_in && (sfr_addr_in == ADDR_CONTROL_STATUS);
  assign wr_seq = sfr_wr_in && (sfr_addr_in == ADDR_SEQUENCE_CONTROL);
  assign wr_single = sfr_wr_in && (sfr_addr_in == ADDR_SINGLE_CONVERSION);
  assign rd_high = sfr_rd_in && (sfr_addr_in == ADDR_RESULT_HIGH);

  // start bit only counts with software selection in the same write
  assign sw_start = wr_ctrl && sfr_wdata_in[CTRL_START_BIT]
                    && (sfr_wdata_in[CTRL_START_EVENT_SELECT_LSB +: 2] == START_EVENT_SELECT_SOFTWARE);

  always_comb
  begin
    unique case (start_event_select)
      START_EVENT_SELECT_EXT_PIN: seq_trigger = sw_start || (ext_sync && !ext_prev);
      START_EVENT_SELECT_FREE_RUN: seq_trigger = 1'b1;
      START_EVENT_SELECT_TIMER: seq_trigger = sw_start || timer_compare_in;
      START_EVENT_SELECT_SOFTWARE: seq_trigger = sw_start;
    endcase
  end

  assign single_req = wr_single || single_pending;
  assign pick_first = pick(seq_first_of(sequence_control_reg.channel), sequence_control_reg.channel,
                           analog_pin_config_in);
  assign pick_next = pick({1'b0, cur_ch} + 5'h01, sequence_control_reg.channel, analog_pin_config_in);
  assign seq_last_conv = !pick_next.found || (sequence_control_reg.channel >= CHAN_FIRST_LONE);

  // ****************************************
  // external trigger synchroniser
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end
    else
    begin
      ext_meta <= external_trigger_pin_in;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  // single conversion has priority over starting any new sequence
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state <= ST_IDLE;
      cur_ch <= '0;
      conv_cfg_out <= '0;
      conv_start_out <= 1'b0;
      sequence_start_bit <= 1'b0;
      single_pending <= 1'b0;
    end
    else
    begin
      conv_start_out <= 1'b0;
      unique case (state)
        ST_IDLE:
        begin
          if (single_req)
          begin
            state <= ST_SINGLE;
            conv_cfg_out <= wr_single ? adcseq_cfg_s'(sfr_wdata_in) : single_conversion_reg;
            conv_start_out <= 1'b1;
            single_pending <= 1'b0;
          end
          else if (seq_trigger && pick_first.found)
          begin
            state <= ST_SEQ;
            cur_ch <= pick_first.channel;
            conv_cfg_out <= {sequence_control_reg.reference_select, sequence_control_reg.decimation_select,
                             pick_first.channel};
            conv_start_out <= 1'b1;
            sequence_start_bit <= sw_start;
          end
        end
        ST_SEQ:
        begin
          if (wr_single)
          begin
            single_pending <= 1'b1;
          end
          if (conv_done && !seq_last_conv)
          begin
            cur_ch <= pick_next.channel;
            conv_cfg_out.channel <= pick_next.channel;
            conv_start_out <= 1'b1;
          end
          else if (conv_done)
          begin
            sequence_start_bit <= 1'b0;
            if (single_req)
            begin
              state <= ST_SINGLE;
              conv_cfg_out <= wr_single ? adcseq_cfg_s'(sfr_wdata_in) : single_conversion_reg;
              conv_start_out <= 1'b1;
              single_pending <= 1'b0;
            end
            else if ((start_event_select == START_EVENT_SELECT_FREE_RUN) && pick_first.found)
            begin
              cur_ch <= pick_first.channel;
              conv_cfg_out.channel <= pick_first.channel;
              conv_start_out <= 1'b1;
            end
            else
            begin
              state <= ST_IDLE;
            end
          end
        end
        ST_SINGLE:
        begin
          if (wr_single)
          begin
            single_pending <= 1'b1;
          end
          if (conv_done)
          begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  adcseq_conv_timer u_timer
  (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .start_in(conv_start_out),
    .decimation_select_in(conv_cfg_out.decimation_select),
    .busy_out(),
    .done_out(conv_done)
  );

  assign conv_busy_out = (state != ST_IDLE);

  // ****************************************
  // results and done flag
  // ****************************************
  // set beats a read of the high byte in the same cycle
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      result <= RESULT_RST;
      done_flag <= 1'b0;
    end
    else
    begin
      if (conv_done)
      begin
        result <= conv_data_in;
        done_flag <= 1'b1;
      end
      else if (rd_high)
      begin
        done_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // interrupt and DMA pulses
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      irq_out <= 1'b0;
      any_channel_dma_trigger_out <= 1'b0;
      per_channel_dma_trigger_out <= '0;
    end
    else
    begin
      irq_out <= conv_done && (state == ST_SINGLE);
      any_channel_dma_trigger_out <= conv_done && (state == ST_SEQ);
      for (int i = 0; i < PIN_COUNT; i++)
      begin
        per_channel_dma_trigger_out[i] <= conv_done && (state == ST_SEQ) && (cur_ch == CHAN_W'(i));
      end
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  // reference and decimation are taken when a single or a sequence from idle starts, not at later sequence conversions
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      start_event_select <= START_EVENT_SELECT_SOFTWARE;
      ctrl_low <= CTRL_LOW_RST;
      sequence_control_reg <= SEQ_CFG_RST;
      single_conversion_reg <= SINGLE_CFG_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        start_event_select <= adcseq_start_sel_e'(sfr_wdata_in[CTRL_START_EVENT_SELECT_LSB +: 2]);
        ctrl_low <= sfr_wdata_in[CTRL_LOW_MSB:0];
      end
      if (wr_seq)
      begin
        sequence_control_reg <= adcseq_cfg_s'(sfr_wdata_in);
      end
      if (wr_single)
      begin
        single_conversion_reg <= adcseq_cfg_s'(sfr_wdata_in);
      end
    end
  end

  // ****************************************
  // channel readback
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      channel_view <= SEQ_CFG_RST[CHAN_W-1:0];
    end
    else if (wr_seq)
    begin
      channel_view <= sfr_wdata_in[CHAN_W-1:0];
    end
    else if (conv_start_out && (state == ST_SEQ))
    begin
      channel_view <= cur_ch;
    end
    else if (conv_done && (state == ST_SEQ) && seq_last_conv)
    begin
      channel_view <= (sequence_control_reg.channel >= CHAN_FIRST_LONE) ? sequence_control_reg.channel
                      : cur_ch + CHAN_W'(1);
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  // unmapped addresses read as zero
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sfr_rdata_out <= 8'h00;
    end
    else if (sfr_rd_in)
    begin
      unique case (sfr_addr_in)
        ADDR_CONTROL_STATUS: sfr_rdata_out <= {done_flag, sequence_start_bit, start_event_select, ctrl_low};
        ADDR_SEQUENCE_CONTROL: sfr_rdata_out <= {sequence_control_reg[7:CHAN_W], channel_view};
        ADDR_SINGLE_CONVERSION: sfr_rdata_out <= single_conversion_reg;
        ADDR_RESULT_LOW: sfr_rdata_out <= {result[RESULT_LOW_W-1:0], LOW_PAD};
        ADDR_RESULT_HIGH: sfr_rdata_out <= result[RESULT_W-1:RESULT_LOW_W];
        default: sfr_rdata_out <= 8'h00;
      endcase
    end
  end

endmodule : adcseq_top
